// >>> rtl/sbmb_boot_baud.sv
// boot-mode selection, debug handshake, status message and baud divisor
//
// Functional notes
// [RULE_01] after self-test, send one 0x00 invitation byte on the debug port
// [RULE_02] ack byte 0x4F within 500 ms of invitation enters debug mode
// [RULE_03] timeout or any other byte continues normal startup without debug
// [RULE_04] debug mode stops automatic script execution; debugger bytes drive it
// [RULE_05] debug link fixed at 9600 baud, 8 data, no parity, 1 stop
// [RULE_06] host disables hardware and software flow control on its port
// [RULE_07] setup select pin low at reset starts configuration mode, no application
// [RULE_08] configuration mode passes main port bytes on as setup data
// [RULE_09] configuration start sends a text status message on the main port
// [RULE_10] baud reference is crystal divided by 32, 1.25 MHz from 40 MHz
// [RULE_11] divisor is reference over requested rate, rounded half up
// [RULE_12] any integer rate accepted; nearest achievable divisor chosen; code refuses a zero rate and any rate whose rounded divisor is 0
// [RULE_13] deviation under 2 percent is flagged acceptable
// [RULE_14] main port defaults to 9600 baud, reprogrammable at run time
// [RULE_15] main port spans 110 baud to 625 kbaud; chosen rate held
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ns
module sbmb_boot_baud
    import sbmb_pkg::*;
#(
    parameter int unsigned ACK_WINDOW_CYCLES = ACK_WINDOW_CYC
)(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        setupSelectPinN,
    input  wire logic        debugRxd,
    output logic             debugTxd,
    input  wire logic        mainRxd,
    output logic             mainTxd,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic [31:0]      regRdata,
    output logic             setup_select_pin,
    output logic             debugMode,
    output logic             scriptRun,
    output logic             debugByteValid,
    output logic [7:0]       debugByte,
    output logic             cfgByteValid,
    output logic [7:0]       cfgByte
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        S_CAPTURE, S_SELFTEST, S_INVITE, S_ACK_WAIT,
        S_MSG_FETCH, S_MSG_SEND, S_CONFIG, S_DEBUG_RUN
    } sbmb_state_type;
    localparam sbmb_state_type S_RUN = S_DEBUG_RUN;

    sbmb_state_type     state_reg;
    logic               inDebug_reg;
    logic               cfgSel_reg;
    logic [CNT_W-1:0]   waitCnt_reg;
    logic [MSG_AW-1:0]  msgIdx_reg;
    logic [W-1:0]       mainDiv_reg;
    logic [W-1:0]       rate_reg;
    logic [W-1:0]       halfRate_reg;
    logic [W-1:0]       divNum_reg;
    logic [W-1:0]       divQuo_reg;
    logic [W-1:0]       divRem_reg;
    logic [4:0]         divCnt_reg;
    logic               divBusy_reg;
    logic               divDone_reg;
    logic               rateOk_reg;
    logic               refused_reg;
    logic               inRange_reg;
    logic [7:0]         rxHold_reg;
    logic               rxFull_reg;
    logic [31:0]        statusWord;
    logic [W-1:0]       errAbs;
    logic [1:0]         txStart;
    logic [1:0]         txBusy;
    logic [1:0]         rxValid;
    logic [1:0]         rxd;
    logic [1:0]         txd;
    logic [7:0]         txByte [2];
    logic [7:0]         rxData [2];
    logic [W-1:0]       chDiv [2];
    logic               msgSend;
    logic               hostTx;
    logic               rateWr;
    logic [W:0]         remShift;
    logic               remFits;
    logic               ackSeen;

    sbmb_rom_if romBus ();

    sbmb_status_rom uRom (
        .sys_clk (sys_clk),
        .romPort (romBus)
    );

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // startup sequence
    // ------------------------------------------------------------
    assign ackSeen = rxValid[0] && (rxData[0] == ACK_BYTE);
    assign msgSend = (state_reg == S_MSG_SEND) && !txBusy[1];
    assign romBus.addr = msgIdx_reg;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg   <= S_CAPTURE;
            inDebug_reg <= 1'b0;
            cfgSel_reg  <= 1'b0;
            waitCnt_reg <= '0;
            msgIdx_reg  <= '0;
        end else begin
            case (state_reg)
                S_CAPTURE: begin
                    // pin level caught on the first clock after release
                    cfgSel_reg  <= !setupSelectPinN; // [RULE_07]
                    waitCnt_reg <= '0;
                    state_reg   <= S_SELFTEST;
                end
                S_SELFTEST: begin
                    if (waitCnt_reg == SELFTEST_CYC - 1'b1) begin
                        waitCnt_reg <= '0;
                        msgIdx_reg  <= '0;
                        state_reg   <= cfgSel_reg ? S_MSG_FETCH : S_INVITE; // [RULE_07]
                    end else begin
                        waitCnt_reg <= waitCnt_reg + 1'b1;
                    end
                end
                S_INVITE: begin
                    waitCnt_reg <= '0;
                    state_reg   <= S_ACK_WAIT; // [RULE_01]
                end
                S_ACK_WAIT: begin
                    // window opens with the invitation byte itself
                    if (rxValid[0]) begin
                        inDebug_reg <= ackSeen; // [RULE_02] [RULE_03]
                        state_reg   <= S_DEBUG_RUN;
                    end else if (waitCnt_reg == CNT_W'(ACK_WINDOW_CYCLES - 1)) begin
                        state_reg   <= S_RUN; // [RULE_03]
                    end else begin
                        waitCnt_reg <= waitCnt_reg + 1'b1;
                    end
                end
                S_MSG_FETCH: begin
                    state_reg <= S_MSG_SEND;
                end
                S_MSG_SEND: begin
                    if (msgSend) begin
                        msgIdx_reg <= msgIdx_reg + 1'b1;
                        state_reg  <= (msgIdx_reg == MSG_LAST) ? S_CONFIG : S_MSG_FETCH; // [RULE_09]
                    end
                end
                S_CONFIG, S_DEBUG_RUN: begin
                    state_reg <= state_reg;
                end
                default: begin
                    state_reg <= S_CAPTURE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // mode outputs and byte forwarding
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            setup_select_pin     <= 1'b0;
            debugMode      <= 1'b0;
            scriptRun      <= 1'b0;
            debugByteValid <= 1'b0;
            debugByte      <= '0;
            cfgByteValid   <= 1'b0;
            cfgByte        <= '0;
        end else begin
            setup_select_pin     <= (state_reg == S_CONFIG); // [RULE_07]
            debugMode      <= (state_reg == S_DEBUG_RUN) && inDebug_reg;
            // halted scripts only move on bytes from the debugger
            scriptRun      <= (state_reg == S_RUN) && !inDebug_reg; // [RULE_04]
            debugByteValid <= rxValid[0] && (state_reg == S_DEBUG_RUN) && inDebug_reg; // [RULE_04]
            debugByte      <= rxData[0];
            cfgByteValid   <= rxValid[1] && (state_reg == S_CONFIG); // [RULE_08]
            cfgByte        <= rxData[1];
        end
    end

    // ------------------------------------------------------------
    // baud divisor: restoring divide, one quotient bit per clock
    // ------------------------------------------------------------
    assign rateWr   = regWrite && (regAddr == ADDR_RATE) && !divBusy_reg && (regWdata[W-1:0] != '0);
    assign remShift = {divRem_reg, divNum_reg[W-1]};
    assign remFits  = remShift >= {1'b0, rate_reg};

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rate_reg     <= W'(DEFAULT_BAUD);
            halfRate_reg <= '0;
            divNum_reg   <= '0;
            divQuo_reg   <= '0;
            divRem_reg   <= '0;
            divCnt_reg   <= '0;
            divBusy_reg  <= 1'b0;
            divDone_reg  <= 1'b0;
        end else begin
            divDone_reg <= divBusy_reg && (divCnt_reg == 5'(W - 1));
            if (rateWr) begin
                rate_reg     <= regWdata[W-1:0];
                halfRate_reg <= {1'b0, regWdata[W-1:1]};
                // adding half the rate gives round-half-up
                divNum_reg   <= W'(REF_HZ) + {1'b0, regWdata[W-1:1]}; // [RULE_10] [RULE_11]
                divRem_reg   <= '0;
                divCnt_reg   <= '0;
                divBusy_reg  <= 1'b1;
            end else if (divBusy_reg) begin
                divNum_reg <= {divNum_reg[W-2:0], 1'b0};
                divRem_reg <= remFits ? W'(remShift - {1'b0, rate_reg}) : remShift[W-1:0];
                divQuo_reg <= {divQuo_reg[W-2:0], remFits}; // [RULE_11]
                divBusy_reg <= (divCnt_reg != 5'(W - 1));
                divCnt_reg <= divCnt_reg + 1'b1;
            end
        end
    end

    // reference minus divisor times rate, as a magnitude
    assign errAbs = (divRem_reg >= halfRate_reg) ? divRem_reg - halfRate_reg : halfRate_reg - divRem_reg;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mainDiv_reg <= DEFAULT_DIV; // [RULE_14]
            rateOk_reg  <= 1'b1;
            inRange_reg <= 1'b1;
            refused_reg <= 1'b0;
        end else if (divDone_reg) begin
            if (divQuo_reg != '0) begin
                // held until software asks for another rate
                mainDiv_reg <= divQuo_reg; // [RULE_12] [RULE_15]
                rateOk_reg  <= 48'(errAbs) * 48'(PCT_SCALE) < 48'(TOL_PCT) * 48'(divQuo_reg) * 48'(rate_reg); // [RULE_13]
                inRange_reg <= (rate_reg >= W'(MIN_BAUD)) && (rate_reg <= W'(MAX_BAUD)); // [RULE_15]
                refused_reg <= 1'b0;
            end else begin
                refused_reg <= 1'b1;
            end
        end else if (regWrite && (regAddr == ADDR_RATE) && !rateWr) begin
            refused_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // serial channels: 0 debug, 1 main
    // ------------------------------------------------------------
    assign hostTx    = regWrite && (regAddr == ADDR_TXDATA) && !txBusy[1] && (state_reg != S_MSG_SEND);
    assign txStart   = {msgSend || hostTx, state_reg == S_INVITE};
    assign txByte[0] = INVITE_BYTE; // [RULE_01]
    assign txByte[1] = msgSend ? romBus.data : regWdata[7:0];
    assign chDiv[0]  = DEBUG_DIV; // [RULE_05]
    assign chDiv[1]  = mainDiv_reg; // [RULE_14]
    assign rxd       = {mainRxd, debugRxd};
    assign debugTxd  = txd[0];
    assign mainTxd   = txd[1];

    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        logic [TMR_W-1:0] txCnt_reg;
        logic [3:0]       txBits_reg;
        logic [9:0]       txShift_reg;
        logic [TMR_W-1:0] rxCnt_reg;
        logic [3:0]       rxBits_reg;
        logic [7:0]       rxShift_reg;
        logic             rxBusy_reg;
        logic             rxValid_reg;
        logic [TMR_W-1:0] bitCyc;
        logic [TMR_W-1:0] rxTarget;

        assign bitCyc   = TMR_W'(chDiv[ch]) * TMR_W'(REF_TICK_CYC); // [RULE_10]
        assign rxTarget = (rxBits_reg == '0) ? {1'b0, bitCyc[TMR_W-1:1]} : bitCyc;

        // 8N1 only: start, eight data lsb first, one stop
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                txCnt_reg   <= '0;
                txBits_reg  <= '0;
                txShift_reg <= '1;
            end else if (txBits_reg == '0) begin
                if (txStart[ch]) begin
                    txShift_reg <= {1'b1, txByte[ch], 1'b0}; // [RULE_05]
                    txBits_reg  <= FRAME_BITS;
                    txCnt_reg   <= '0;
                end
            end else if (txCnt_reg >= bitCyc - 1'b1) begin
                txCnt_reg   <= '0;
                txShift_reg <= {1'b1, txShift_reg[9:1]};
                txBits_reg  <= txBits_reg - 1'b1;
            end else begin
                txCnt_reg <= txCnt_reg + 1'b1;
            end
        end

        // mid-bit sampling; a start bit high again at mid-bit is dropped
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                rxCnt_reg   <= '0;
                rxBits_reg  <= '0;
                rxShift_reg <= '0;
                rxBusy_reg  <= 1'b0;
                rxValid_reg <= 1'b0;
            end else begin
                rxValid_reg <= 1'b0;
                if (!rxBusy_reg) begin
                    rxBusy_reg <= !rxd[ch];
                    rxCnt_reg  <= '0;
                    rxBits_reg <= '0;
                end else if (rxCnt_reg < rxTarget - 1'b1) begin
                    rxCnt_reg <= rxCnt_reg + 1'b1;
                end else begin
                    rxCnt_reg <= '0;
                    if (rxBits_reg == '0) begin
                        rxBusy_reg <= !rxd[ch];
                        rxBits_reg <= 4'h1;
                    end else if (rxBits_reg != STOP_IDX) begin
                        rxShift_reg <= {rxd[ch], rxShift_reg[7:1]};
                        rxBits_reg  <= rxBits_reg + 1'b1;
                    end else begin
                        // framing error drops the byte silently
                        rxBusy_reg  <= 1'b0;
                        rxValid_reg <= rxd[ch]; // [RULE_05]
                    end
                end
            end
        end

        assign txd[ch]    = txShift_reg[0];
        assign txBusy[ch] = (txBits_reg != '0);
        assign rxValid[ch] = rxValid_reg;
        assign rxData[ch] = rxShift_reg;
    end

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    always_comb begin
        statusWord              = '0;
        statusWord[ST_CFG]      = setup_select_pin;
        statusWord[ST_DBG]      = debugMode;
        statusWord[ST_RUN]      = scriptRun;
        statusWord[ST_DIV_BUSY] = divBusy_reg || divDone_reg;
        statusWord[ST_RATE_OK]  = rateOk_reg;
        statusWord[ST_REFUSED]  = refused_reg;
        statusWord[ST_TX_BUSY]  = txBusy[1];
        statusWord[ST_IN_RANGE] = inRange_reg;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxHold_reg <= '0;
            rxFull_reg <= 1'b0;
        end else if (rxValid[1]) begin
            // a new byte wins over a read in the same cycle
            rxHold_reg <= rxData[1];
            rxFull_reg <= 1'b1;
        end else if (regRead && (regAddr == ADDR_RXDATA)) begin
            rxFull_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= '0;
        end else if (regRead) begin
            case (regAddr)
                ADDR_RATE:   regRdata <= 32'(rate_reg);
                ADDR_DIV:    regRdata <= 32'(mainDiv_reg);
                ADDR_STATUS: regRdata <= statusWord;
                ADDR_RXDATA: regRdata <= {23'h000000, rxFull_reg, rxHold_reg};
                default:     regRdata <= '0;
            endcase
        end else begin
            regRdata <= '0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_INVITE_ZERO: assert property ((state_reg == S_INVITE) |=> !debugTxd && g_chan[0].txShift_reg[8:1] == INVITE_BYTE) // [RULE_01]
        else $error("invitation frame is not a zero byte");
    AST_ACK_DEBUG: assert property ((state_reg == S_ACK_WAIT) && ackSeen |=> ##1 debugMode && !scriptRun) // [RULE_02]
        else $error("ack byte did not enter debug mode");
    AST_NO_ACK_RUN: assert property ((state_reg == S_ACK_WAIT) && !rxValid[0]
        && waitCnt_reg == CNT_W'(ACK_WINDOW_CYCLES - 1) |=> ##1 scriptRun && !debugMode) // [RULE_03]
        else $error("window expiry did not continue startup");
    AST_DEBUG_HALTS: assert property (debugMode |-> !scriptRun && !setup_select_pin) // [RULE_04]
        else $error("script runs during debug mode");
    AST_DEBUG_BIT_TIME: assert property ($fell(txBusy[0]) |-> $past(g_chan[0].txCnt_reg) == TMR_W'(DEBUG_DIV) * TMR_W'(REF_TICK_CYC) - 1'b1) // [RULE_05]
        else $error("debug bit time wrong");
    AST_CFG_NO_APP: assert property ($rose(setup_select_pin) |-> !scriptRun ##1 !scriptRun && !debugMode) // [RULE_07]
        else $error("application active in configuration mode");
    AST_CFG_STREAM: assert property (rxValid[1] && (state_reg == S_CONFIG) |=> cfgByteValid && cfgByte == $past(rxData[1])) // [RULE_08]
        else $error("configuration byte not forwarded");
    AST_MSG_BEFORE_CFG: assert property ($rose(state_reg == S_CONFIG) |-> $past(txStart[1]) && $past(msgIdx_reg) == MSG_LAST) // [RULE_09]
        else $error("configuration entered before full status message");
    AST_DIV_ROUND: assert property (divDone_reg |-> 48'(divQuo_reg) * 48'(rate_reg) + 48'(divRem_reg)
        == 48'(REF_HZ) + 48'(halfRate_reg) && divRem_reg < rate_reg) // [RULE_11]
        else $error("divisor is not rounded quotient");
    AST_DIV_LOAD: assert property (divDone_reg && divQuo_reg != '0 |=> mainDiv_reg == $past(divQuo_reg) && !refused_reg) // [RULE_12]
        else $error("divisor not taken");

    COV_DEBUG: cover property ((state_reg == S_ACK_WAIT) && ackSeen ##2 debugMode);
    COV_CONFIG: cover property ($rose(setup_select_pin));
    COV_RUN: cover property ($rose(scriptRun));
    COV_NEW_RATE: cover property (divDone_reg && divQuo_reg != '0 ##1 mainDiv_reg != DEFAULT_DIV);
endmodule

// >>> rtl/sbmb_pkg.sv
// shared constants for the serial boot-mode and baud block
package sbmb_pkg;
    // ------------------------------------------------------------
    // clocks and baud reference
    // ------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ    = 20_000_000;
    localparam int unsigned CRYSTAL_HZ    = 40_000_000;
    localparam int unsigned REF_PRESCALE  = 32;
    localparam int unsigned REF_HZ        = CRYSTAL_HZ / REF_PRESCALE;
    localparam int unsigned REF_TICK_CYC  = SYS_CLK_HZ / REF_HZ;
    // ------------------------------------------------------------
    // widths and frame
    // ------------------------------------------------------------
    localparam int unsigned W             = 22;
    localparam int unsigned TMR_W         = W + 4;
    localparam int unsigned CNT_W         = 24;
    localparam logic [3:0]  FRAME_BITS    = 4'ha;
    localparam logic [3:0]  STOP_IDX      = 4'h9;
    // ------------------------------------------------------------
    // rates and timing
    // ------------------------------------------------------------
    localparam int unsigned DEBUG_BAUD    = 9600;
    localparam int unsigned DEFAULT_BAUD  = 9600;
    localparam int unsigned MIN_BAUD      = 110;
    localparam int unsigned MAX_BAUD      = 625_000;
    localparam int unsigned TOL_PCT       = 2;
    localparam int unsigned PCT_SCALE     = 100;
    localparam logic [W-1:0] DEBUG_DIV    = W'((REF_HZ + DEBUG_BAUD / 2) / DEBUG_BAUD);
    localparam logic [W-1:0] DEFAULT_DIV  = W'((REF_HZ + DEFAULT_BAUD / 2) / DEFAULT_BAUD);
    localparam int unsigned ACK_WINDOW_MS = 500;
    localparam int unsigned ACK_WINDOW_CYC = (SYS_CLK_HZ / 1000) * ACK_WINDOW_MS;
    localparam logic [CNT_W-1:0] SELFTEST_CYC = 24'h000040;
    // ------------------------------------------------------------
    // handshake bytes and status message
    // ------------------------------------------------------------
    localparam logic [7:0]  INVITE_BYTE   = 8'h00;
    localparam logic [7:0]  ACK_BYTE      = 8'h4f;
    localparam int unsigned MSG_LEN       = 32;
    localparam int unsigned MSG_AW        = 5;
    localparam logic [MSG_AW-1:0] MSG_LAST = 5'h1f;
    // ------------------------------------------------------------
    // register map and fields
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_RATE     = 8'h00;
    localparam logic [7:0]  ADDR_DIV      = 8'h04;
    localparam logic [7:0]  ADDR_STATUS   = 8'h08;
    localparam logic [7:0]  ADDR_TXDATA   = 8'h0c;
    localparam logic [7:0]  ADDR_RXDATA   = 8'h10;
    localparam int unsigned ST_CFG        = 0;
    localparam int unsigned ST_DBG        = 1;
    localparam int unsigned ST_RUN        = 2;
    localparam int unsigned ST_DIV_BUSY   = 3;
    localparam int unsigned ST_RATE_OK    = 4;
    localparam int unsigned ST_REFUSED    = 5;
    localparam int unsigned ST_TX_BUSY    = 6;
    localparam int unsigned ST_IN_RANGE   = 7;
    localparam int unsigned RX_FULL_BIT   = 8;
endpackage

// >>> rtl/sbmb_rom_if.sv
// status message store port bundle
`timescale 1ns/1ns
interface sbmb_rom_if import sbmb_pkg::*; ();
    logic [MSG_AW-1:0] addr;
    logic [7:0]        data;
    modport reader (output addr, input data);
    modport store  (input addr, output data);
endinterface

// >>> rtl/sbmb_status_rom.sv
// status message text store with registered read data
`timescale 1ns/1ns
module sbmb_status_rom
    import sbmb_pkg::*;
(
    input wire logic    sys_clk,
    sbmb_rom_if.store   romPort
);
    // firmware, script, author, version, date and serial fields; values arbitrary
    localparam logic [8*MSG_LEN-1:0] MSG_TEXT = "FW1 S=empty A=none V=1 D=0 N=0\r\n";

    always_ff @(posedge sys_clk) begin
        romPort.data <= MSG_TEXT[8*(MSG_LEN-1-int'(romPort.addr)) +: 8];
    end
endmodule

// >>> test/sbmb_host_model.sv
// host model answering on the debug serial port
`timescale 1ns/1ns
module sbmb_host_model (
    input  wire logic       sys_clk,
    input  wire logic       debugTxd,
    input  wire logic [7:0] replyByte,
    output logic            debugRxd
);
    localparam int BIT = 2080;
    initial begin
        logic [9:0] frame;
        debugRxd = 1'b1;
        @(negedge debugTxd);
        // reply port is settled by now, not yet at time zero
        frame = {1'b1, replyByte, 1'b0};
        // reply only once the whole invitation is in
        repeat (10 * BIT) @(posedge sys_clk);
        // no flow control lines: ack, then one debugger command byte, unasked
        for (int i = 0; i < 20; i++) begin
            debugRxd <= frame[i % 10];
            repeat (BIT) @(posedge sys_clk);
        end
    end
endmodule

// >>> test/sbmb_boot_baud_tb.sv
// testbench of the boot-mode and baud block
`timescale 1ns/1ns
module sbmb_boot_baud_tb;
    import sbmb_pkg::*;
    logic sys_clk, rst_n, setupSelectPinN, debugRxd, debugTxd, mainTxd, mainRxd;
    logic regWrite, regRead, setup_select_pin, debugMode, scriptRun, debugByteValid, cfgByteValid;
    logic [7:0] regAddr, debugByte, cfgByte;
    logic [31:0] regWdata, regRdata, v;
    int n_fail, comparisons, cycles;
    logic [31:0] rateTab [6] = '{32'h2580, 32'h9600, 32'h98968, 32'h7a120, 32'h32, 32'h6e};
    logic [31:0] divTab [6] = '{32'h82, 32'h21, 32'h2, 32'h3, 32'h61a8, 32'h2c64};
    logic [3:0] stTab [6] = '{4'h9, 4'h9, 4'h9, 4'h8, 4'h1, 4'h9};
    sbmb_boot_baud #(.ACK_WINDOW_CYCLES(50000)) u_sbmb_boot_baud (.sys_clk(sys_clk), .rst_n(rst_n),
        .setupSelectPinN(setupSelectPinN), .debugRxd(debugRxd), .debugTxd(debugTxd), .mainRxd(mainRxd),
        .mainTxd(mainTxd), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .setup_select_pin(setup_select_pin), .debugMode(debugMode), .scriptRun(scriptRun),
        .debugByteValid(debugByteValid), .debugByte(debugByte), .cfgByteValid(cfgByteValid),
        .cfgByte(cfgByte));
    sbmb_host_model u_sbmb_host_model (.sys_clk(sys_clk), .debugTxd(debugTxd), .replyByte(8'h4f),
        .debugRxd(debugRxd));
    // far end of the main port echoes the line, so sent bytes come back
    always @(posedge sys_clk) mainRxd <= mainTxd;
    // ----------------------------------------
    // bus tasks and checks
    // ----------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk) begin regAddr <= a; regWdata <= d; regWrite <= 1'b1; end
        @(posedge sys_clk) regWrite <= 1'b0;
        repeat (25) @(posedge sys_clk);
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk) begin regAddr <= a; regRead <= 1'b1; end
        @(posedge sys_clk) regRead <= 1'b0;
        #1 d = regRdata;
    endtask
    task complete_run();
        $display("errors %0d of %0d checks", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // cut a hang well past the longest handshake
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 90000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        rst_n = 1'b0; setupSelectPinN = 1'b1; regAddr = 8'h00; regWdata = 32'h0; regWrite = 1'b0; regRead = 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(ADDR_DIV, v); chk(v, 32'h82);
        rd(ADDR_RATE, v); chk(v, 32'h2580);
        @(negedge debugTxd);
        repeat (1040) @(posedge sys_clk);
        for (int i = 0; i < 10; i++) begin
            chk(debugTxd, i == 9);
            repeat (2080) @(posedge sys_clk);
        end
        for (int i = 0; i < 6; i++) begin
            wr(ADDR_RATE, rateTab[i]);
            rd(ADDR_DIV, v); chk(v, divTab[i]);
            rd(ADDR_STATUS, v); chk(v[7:4], stTab[i]);
        end
        wr(ADDR_RATE, 32'h0);
        rd(ADDR_STATUS, v); chk(v[5], 1'b1);
        rd(ADDR_DIV, v); chk(v, 32'h2c64);
        for (int i = 0; i < 25000 && debugMode !== 1'b1; i++) @(posedge sys_clk);
        chk({debugMode, scriptRun}, 2'b10);
        for (int i = 0; i < 25000 && debugByteValid !== 1'b1; i++) @(posedge sys_clk);
        chk({debugByteValid, debugByte}, 9'h14f);
        rst_n <= 1'b0;
        setupSelectPinN <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        // fastest rate before the message starts keeps all 32 bytes inside the run
        wr(ADDR_RATE, 32'h98968);
        for (int i = 0; i < 200 && mainTxd !== 1'b0; i++) @(posedge sys_clk);
        chk(mainTxd, 1'b0);
        repeat (100) @(posedge sys_clk);
        chk({debugTxd, debugMode, scriptRun}, 3'b100);
        for (int i = 0; i < 11000 && setup_select_pin !== 1'b1; i++) @(posedge sys_clk);
        rd(ADDR_STATUS, v); chk(v[2:0], 3'h1);
        // echoed last message byte lands once configuration mode is up
        for (int i = 0; i < 400 && cfgByteValid !== 1'b1; i++) @(posedge sys_clk);
        chk({cfgByteValid, cfgByte}, 9'h10a);
        repeat (40) @(posedge sys_clk);
        wr(ADDR_TXDATA, 32'h5a);
        for (int i = 0; i < 400 && cfgByteValid !== 1'b1; i++) @(posedge sys_clk);
        chk({cfgByteValid, cfgByte}, 9'h15a);
        rd(ADDR_RXDATA, v); chk(v, 32'h15a);
        rd(ADDR_RXDATA, v); chk(v, 32'h5a);
        complete_run();
    end
endmodule
